/* hdl/err_rec_pkg.sv */
// Shared constants and carrier types for the error record register block
package err_rec_pkg;
	localparam logic [11:0] STATUS_OFF = 12'h010;
	localparam logic [11:0] IRQCFG4_OFF = 12'hE20;
	localparam logic [11:0] IRQCFG5_OFF = 12'hE28;
	localparam logic [11:0] CRIT_ADDR_OFF = 12'hEA0;
	localparam logic [11:0] CRIT_PAYLOAD_OFF = 12'hEA8;
	localparam logic [11:0] CRIT_ATTR_OFF = 12'hEAC;
	localparam logic [11:0] ID0_OFF = 12'hFF0;
	localparam logic [11:0] ID1_OFF = 12'hFF4;
	localparam logic [11:0] ID2_OFF = 12'hFF8;
	localparam logic [11:0] ID3_OFF = 12'hFFC;

	localparam logic [7:0] ID_SEG0 = 8'h0D;
	localparam logic [3:0] ID_CLASS = 4'hF;
	localparam logic [3:0] ID_SEG1 = 4'h0;
	localparam logic [7:0] ID_SEG2 = 8'h05;
	localparam logic [7:0] ID_SEG3 = 8'hB1;

	// Status field positions
	localparam int V_BIT = 30;
	localparam int UE_BIT = 29;
	localparam int OF_BIT = 27;
	localparam int CE_MSB = 25;
	localparam int CE_LSB = 24;
	localparam int DE_BIT = 23;
	localparam logic [63:0] V11_MASK = 64'h0000_0000_6B80_0000;
	localparam logic [63:0] ERR_MASK = 64'h0000_0000_2380_0000;
	localparam logic [63:0] SYN_MASK = 64'h0000_0000_9478_FFFF;

	localparam int ADDR_LSB = 2;
	localparam int ADDR_MSB = 55;
	localparam int ADDR_W = ADDR_MSB - ADDR_LSB + 1;
	localparam int NS_BIT = 6;
	localparam int EN_BIT = 7;

	localparam logic [63:0] STATUS_RST = 64'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST = '0;
	localparam logic [31:0] PAYLOAD_RST = 32'h0;
	localparam logic NS_RST = 1'b0;
	localparam logic EN_RST = 1'b0;

	typedef struct packed {
		logic valid;
		logic write;
		logic nonsecure;
		logic realm;
		logic [11:0] addr;
		logic [63:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic rvalid;
		logic [63:0] rdata;
	} reg_rsp_t;

	typedef struct packed {
		logic valid;
		logic [63:0] value;
	} err_event_t;

	typedef struct packed {
		logic [63:0] addr;
		logic [31:0] data;
		logic nonsecure;
	} msi_t;
endpackage : err_rec_pkg

/* hdl/status_write_filter.sv */
// Candidate value filter for software writes to the error record status
module status_write_filter
	import err_rec_pkg::*;
#(
	parameter bit REV_1P1 = 1'b1
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [63:0] old_val,
	input wire logic [63:0] wdata,
	output logic [63:0] cand
);
	logic [63:0] c;
	logic hi_clear;

	always_comb begin
		c = {wdata[63:32], old_val[31:16] & ~wdata[31:16], wdata[15:0]};
		hi_clear = 1'b0;
		if (REV_1P1) begin
			if ((c & V11_MASK) != 64'h0) begin
				c = old_val;
			end
		end else begin
			if (c[OF_BIT]) begin
				c = (c & ~ERR_MASK) | (old_val & ERR_MASK);
			end
			if ((c & ERR_MASK) != 64'h0) begin
				c[V_BIT] = old_val[V_BIT];
			end
			// Syndrome survives unless the top-priority error is being cleared
			hi_clear = c[UE_BIT] || (!old_val[UE_BIT] && c[DE_BIT]) ||
				(!old_val[UE_BIT] && !old_val[DE_BIT] && (c[CE_MSB:CE_LSB] != 2'h0));
			if (hi_clear) begin
				c = (c & ~SYN_MASK) | (old_val & SYN_MASK);
			end
		end
		cand = c;
	end

	a_rev11_discard: assert property (@(posedge clk) disable iff (!reset_n)
		REV_1P1 && ((cand & V11_MASK) != 64'h0) |-> cand == old_val)
		else $error("Status write not discarded while flags stay set");
	a_rev10_overflow: assert property (@(posedge clk) disable iff (!reset_n)
		!REV_1P1 && cand[OF_BIT] |-> (cand & ERR_MASK) == (old_val & ERR_MASK))
		else $error("Error fields changed while overflow stays set");
	a_rev10_valid: assert property (@(posedge clk) disable iff (!reset_n)
		!REV_1P1 && ((cand & ERR_MASK) != 64'h0) |-> cand[V_BIT] == old_val[V_BIT])
		else $error("Valid bit changed while error fields stay set");
endmodule : status_write_filter

/* hdl/crit_msi_sender.sv */
// Issues the critical error message-signaled interrupt write
module crit_msi_sender
	import err_rec_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic fire,
	input msi_t target,
	output logic msi_valid,
	input wire logic msi_ready,
	output msi_t msi_out
);
	typedef struct packed {
		logic busy;
		logic pending;
		msi_t msg;
	} sender_state_t;

	sender_state_t st_reg;
	sender_state_t st_next;

	always_comb begin
		st_next = st_reg;
		if (st_reg.busy && msi_ready) begin
			st_next.busy = 1'b0;
		end
		// One event may wait behind a stalled write; further ones merge into it
		if (fire && st_reg.busy && !msi_ready) begin
			st_next.pending = 1'b1;
		end else if ((fire || st_reg.pending) && !st_next.busy) begin
			st_next.busy = 1'b1;
			st_next.pending = 1'b0;
			st_next.msg = target;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign msi_valid = st_reg.busy;
	assign msi_out = st_reg.msg;

	a_msi_hold: assert property (@(posedge clk) disable iff (!reset_n)
		msi_valid && !msi_ready |=> msi_valid && $stable(msi_out))
		else $error("Interrupt write dropped or changed before acceptance");
endmodule : crit_msi_sender

/* hdl/error_record_regs.sv */
// Error record status, identification and critical interrupt register bank
// Contract
// - Status candidate: data high, W1C middle, data low
// - Newer revision: discard write if flags remain
// - Older revision: overflow kept keeps error fields
// - Older revision: error fields kept keep valid
// - Older revision: syndrome kept unless top error cleared
// - Word at 0xFF0 reads 0x0D low byte
// - Word at 0xFF4 class field reads 0xF
// - Word at 0xFF4 low nibble zero, top zero
// - Word at 0xFF8 reads 0x05 low byte
// - Word at 0xFFC reads 0xB1 low byte
// - Absent identification word reads zero, ignores writes
// - Interrupt writes payload to shifted address field
// - Address top and bottom bits read zero
// - Payload register at 0xEA8 holds interrupt data
// - Configuration block views alias same storage
// - Lower-privilege writes blocked while target secure
// - Interrupt registers exist only when configured
// - Bit six selects secure or nonsecure target
// - Status flags clear on one, zero leaves
module error_record_regs
	import err_rec_pkg::*;
#(
	parameter bit REV_1P1 = 1'b1,
	parameter logic [3:0] ID_PRESENT = 4'hF,
	parameter bit IRQCFG_IMPL = 1'b1,
	parameter bit CRIT_IMPL = 1'b1,
	parameter bit RECOMMENDED = 1'b1,
	parameter int PA_BITS = 48
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input reg_req_t REG_REQ,
	output reg_rsp_t REG_RSP,
	input err_event_t ERR_EVENT,
	input wire logic CRIT_EVENT,
	output logic MSI_VALID,
	input wire logic MSI_READY,
	output msi_t MSI_OUT
);
	typedef struct packed {
		logic [63:0] status;
		logic [ADDR_W-1:0] addr_field;
		logic [31:0] payload;
		logic msg_irq_nonsecure;
		logic irq_en;
		reg_rsp_t rsp;
	} bank_state_t;

	bank_state_t st_reg;
	bank_state_t st_next;

	logic cfg_present;
	logic wr_block;
	logic rd_req;
	logic wr_req;
	logic [ADDR_W-1:0] pa_mask;
	logic [63:0] addr_view;
	logic [31:0] attr_view;
	logic [63:0] status_cand;
	logic [63:0] rd_data;
	logic msi_fire;
	msi_t msi_target;

	// Address bits beyond the physical address size are not stored
	genvar gi;
	generate
		for (gi = 0; gi < ADDR_W; gi++) begin : g_pa_mask
			assign pa_mask[gi] = (gi + ADDR_LSB) < PA_BITS;
		end
	endgenerate

	assign cfg_present = IRQCFG_IMPL && (CRIT_IMPL || !RECOMMENDED);
	assign wr_block = (REG_REQ.nonsecure || REG_REQ.realm) && RECOMMENDED && !st_reg.msg_irq_nonsecure;
	assign rd_req = REG_REQ.valid && !REG_REQ.write;
	assign wr_req = REG_REQ.valid && REG_REQ.write;
	assign addr_view = {8'h00, st_reg.addr_field & pa_mask, 2'b00};
	assign attr_view = {24'h000000, st_reg.irq_en, st_reg.msg_irq_nonsecure, 6'h00};

	status_write_filter #(
		.REV_1P1(REV_1P1)
	) u_filter (
		.clk(CLK),
		.reset_n(RESET_N),
		.old_val(st_reg.status),
		.wdata(REG_REQ.wdata),
		.cand(status_cand)
	);

	always_comb begin
		rd_data = 64'h0;
		unique case (REG_REQ.addr)
			STATUS_OFF: begin
				rd_data = st_reg.status;
			end
			CRIT_ADDR_OFF, IRQCFG4_OFF: begin
				rd_data = cfg_present ? addr_view : 64'h0;
			end
			CRIT_PAYLOAD_OFF: begin
				rd_data = cfg_present ? {32'h0, st_reg.payload} : 64'h0;
			end
			IRQCFG5_OFF: begin
				rd_data = cfg_present ? {attr_view, st_reg.payload} : 64'h0;
			end
			CRIT_ATTR_OFF: begin
				rd_data = cfg_present ? {32'h0, attr_view} : 64'h0;
			end
			ID0_OFF: begin
				rd_data = ID_PRESENT[0] ? {56'h0, ID_SEG0} : 64'h0;
			end
			ID1_OFF: begin
				rd_data = ID_PRESENT[1] ? {56'h0, ID_CLASS, ID_SEG1} : 64'h0;
			end
			ID2_OFF: begin
				rd_data = ID_PRESENT[2] ? {56'h0, ID_SEG2} : 64'h0;
			end
			ID3_OFF: begin
				rd_data = ID_PRESENT[3] ? {56'h0, ID_SEG3} : 64'h0;
			end
			default: begin
				rd_data = 64'h0;
			end
		endcase
	end

	always_comb begin
		st_next = st_reg;
		st_next.rsp.rvalid = rd_req;
		if (rd_req) begin
			st_next.rsp.rdata = rd_data;
		end
		// Identification words have no storage, so writes to them fall through
		if (wr_req && REG_REQ.addr == STATUS_OFF) begin
			st_next.status = status_cand;
		end
		if (wr_req && cfg_present && !wr_block) begin
			unique case (REG_REQ.addr)
				CRIT_ADDR_OFF, IRQCFG4_OFF: begin
					st_next.addr_field = REG_REQ.wdata[ADDR_MSB:ADDR_LSB] & pa_mask;
				end
				CRIT_PAYLOAD_OFF: begin
					st_next.payload = REG_REQ.wdata[31:0];
				end
				IRQCFG5_OFF: begin
					st_next.payload = REG_REQ.wdata[31:0];
					st_next.irq_en = REG_REQ.wdata[32 + EN_BIT];
					if (!(REG_REQ.nonsecure || REG_REQ.realm)) begin
						st_next.msg_irq_nonsecure = REG_REQ.wdata[32 + NS_BIT];
					end
				end
				CRIT_ATTR_OFF: begin
					st_next.irq_en = REG_REQ.wdata[EN_BIT];
					if (!(REG_REQ.nonsecure || REG_REQ.realm)) begin
						st_next.msg_irq_nonsecure = REG_REQ.wdata[NS_BIT];
					end
				end
				default: begin
				end
			endcase
		end
		// A recorded error lands after the software write, so the set wins
		if (ERR_EVENT.valid) begin
			st_next.status = st_next.status | ERR_EVENT.value;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			st_reg.status <= STATUS_RST;
			st_reg.addr_field <= ADDR_RST;
			st_reg.payload <= PAYLOAD_RST;
			st_reg.msg_irq_nonsecure <= NS_RST;
			st_reg.irq_en <= EN_RST;
			st_reg.rsp <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign REG_RSP = st_reg.rsp;

	assign msi_fire = CRIT_EVENT && cfg_present && st_reg.irq_en;
	assign msi_target.addr = addr_view;
	assign msi_target.data = st_reg.payload;
	assign msi_target.nonsecure = st_reg.msg_irq_nonsecure;

	crit_msi_sender u_sender (
		.clk(CLK),
		.reset_n(RESET_N),
		.fire(msi_fire),
		.target(msi_target),
		.msi_valid(MSI_VALID),
		.msi_ready(MSI_READY),
		.msi_out(MSI_OUT)
	);

	sequence s_read_at(logic [11:0] off);
		REG_REQ.valid && !REG_REQ.write && REG_REQ.addr == off;
	endsequence

	sequence s_good_write_at(logic [11:0] off);
		REG_REQ.valid && REG_REQ.write && REG_REQ.addr == off && cfg_present && !wr_block;
	endsequence

	a_id0_value: assert property (@(posedge CLK) disable iff (!RESET_N)
		s_read_at(ID0_OFF) |=> REG_RSP.rvalid && REG_RSP.rdata == (ID_PRESENT[0] ? 64'h0D : 64'h0))
		else $error("Identification word zero wrong");
	a_id1_value: assert property (@(posedge CLK) disable iff (!RESET_N)
		s_read_at(ID1_OFF) |=> REG_RSP.rvalid && REG_RSP.rdata == (ID_PRESENT[1] ? 64'hF0 : 64'h0))
		else $error("Identification word one wrong");
	a_id1_low_nibble: assert property (@(posedge CLK) disable iff (!RESET_N)
		s_read_at(ID1_OFF) |=> REG_RSP.rdata[3:0] == 4'h0 && REG_RSP.rdata[63:8] == 56'h0)
		else $error("Identification word one low or top bits set");
	a_id2_value: assert property (@(posedge CLK) disable iff (!RESET_N)
		s_read_at(ID2_OFF) |=> REG_RSP.rdata == (ID_PRESENT[2] ? 64'h05 : 64'h0))
		else $error("Identification word two wrong");
	a_id3_value: assert property (@(posedge CLK) disable iff (!RESET_N)
		s_read_at(ID3_OFF) |=> REG_RSP.rdata == (ID_PRESENT[3] ? 64'hB1 : 64'h0))
		else $error("Identification word three wrong");
	a_id_no_storage: assert property (@(posedge CLK) disable iff (!RESET_N)
		REG_REQ.valid && REG_REQ.write && REG_REQ.addr == ID0_OFF ##1 s_read_at(ID0_OFF)
		|=> REG_RSP.rdata[63:8] == 56'h0)
		else $error("Identification word took a write");
	a_addr_zero_bits: assert property (@(posedge CLK) disable iff (!RESET_N)
		s_read_at(CRIT_ADDR_OFF) |=> REG_RSP.rdata[63:56] == 8'h00 && REG_RSP.rdata[1:0] == 2'b00)
		else $error("Address register reserved bits set");
	a_payload_write: assert property (@(posedge CLK) disable iff (!RESET_N)
		s_good_write_at(CRIT_PAYLOAD_OFF) ##2 s_read_at(IRQCFG5_OFF)
		|=> REG_RSP.rdata[31:0] == $past(REG_REQ.wdata[31:0], 3))
		else $error("Payload alias did not show written value");
	a_alias_addr: assert property (@(posedge CLK) disable iff (!RESET_N)
		s_good_write_at(IRQCFG4_OFF) |=> st_reg.addr_field == ($past(REG_REQ.wdata[ADDR_MSB:ADDR_LSB]) & pa_mask))
		else $error("Address alias write lost");
	a_blocked_write: assert property (@(posedge CLK) disable iff (!RESET_N)
		wr_req && wr_block |=> $stable(st_reg.addr_field) && $stable(st_reg.payload))
		else $error("Blocked interrupt configuration write took effect");
	a_absent_cfg: assert property (@(posedge CLK) disable iff (!RESET_N)
		(!cfg_present and s_read_at(CRIT_ATTR_OFF)) |=> REG_RSP.rdata == 64'h0)
		else $error("Absent configuration register read nonzero");
	a_msi_target: assert property (@(posedge CLK) disable iff (!RESET_N)
		msi_fire && !MSI_VALID |=> MSI_VALID && MSI_OUT.addr == $past(addr_view)
		&& MSI_OUT.data == $past(st_reg.payload) && MSI_OUT.nonsecure == $past(st_reg.msg_irq_nonsecure))
		else $error("Interrupt write target or payload wrong");
	a_status_upper: assert property (@(posedge CLK) disable iff (!RESET_N)
		!REV_1P1 && wr_req && REG_REQ.addr == STATUS_OFF && !ERR_EVENT.valid
		|=> st_reg.status[63:32] == $past(REG_REQ.wdata[63:32]))
		else $error("Status upper half not taken from write");
	a_w1c_zero_keeps: assert property (@(posedge CLK) disable iff (!RESET_N)
		wr_req && REG_REQ.addr == STATUS_OFF && REG_REQ.wdata[31:16] == 16'h0
		|=> (st_reg.status[31:16] & ~$past(st_reg.status[31:16])) == ($past(ERR_EVENT.value[31:16])
		& ~$past(st_reg.status[31:16]) & {16{$past(ERR_EVENT.valid)}}))
		else $error("Status flag changed by a zero write");
endmodule : error_record_regs

/* verification/msi_sink.sv */
// Interrupt controller model that accepts critical interrupt writes
module msi_sink
	import err_rec_pkg::*;
(
	input wire logic clk,
	input wire logic valid,
	input msi_t msg,
	input wire logic [3:0] stall,
	output logic ready,
	output msi_t last,
	output int count
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_cnt;
	initial begin
		ready = 1'b0;
		count = 0;
		wait_cnt = 4'h0;
		last = '0;
	end
	// Ready only after a chosen stall, so slow controllers are covered too
	always @(posedge clk) begin
		if (valid && ready) begin
			last <= msg;
			count <= count + 1;
			ready <= 1'b0;
			wait_cnt <= 4'h0;
		end else if (valid && wait_cnt >= stall) begin
			ready <= 1'b1;
		end else if (valid) begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule : msi_sink

/* verification/error_record_regs_test.sv */
// Register level bench for the error record register bank
module error_record_regs_test;
	import err_rec_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	reg_req_t req = '0;
	reg_rsp_t rsp;
	reg_rsp_t rsp2;
	err_event_t ev = '0;
	logic crit = 1'b0;
	logic msi_valid;
	logic msi2_valid;
	logic msi_ready;
	msi_t msi_out;
	msi_t last;
	int cnt;
	logic [3:0] stall = 4'h0;
	int miscompares = 0;
	int check_count = 0;

	always #50 clk = ~clk;

	// Newer revision, everything present
	error_record_regs #(.REV_1P1(1'b1)) DUT (
		.CLK(clk), .RESET_N(reset_n), .REG_REQ(req), .REG_RSP(rsp), .ERR_EVENT(ev),
		.CRIT_EVENT(crit), .MSI_VALID(msi_valid), .MSI_READY(msi_ready), .MSI_OUT(msi_out));
	// Older revision, last identification word and critical interrupt absent
	error_record_regs #(.REV_1P1(1'b0), .ID_PRESENT(4'h7), .CRIT_IMPL(1'b0)) DUT_OLD (
		.CLK(clk), .RESET_N(reset_n), .REG_REQ(req), .REG_RSP(rsp2), .ERR_EVENT(ev),
		.CRIT_EVENT(crit), .MSI_VALID(msi2_valid), .MSI_READY(1'b1), .MSI_OUT());
	msi_sink SINK (.clk(clk), .valid(msi_valid), .msg(msi_out), .stall(stall),
		.ready(msi_ready), .last(last), .count(cnt));

	task automatic check(input logic [96:0] seen, input logic [96:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [11:0] a, input logic [63:0] d, input logic ns, input logic rl);
		@(posedge clk);
		req <= {1'b1, 1'b1, ns, rl, a, d};
		@(posedge clk);
		req.valid <= 1'b0;
	endtask : wr

	// Answer lands at the taking edge itself, from both banks
	task automatic rd(input logic [11:0] a, input logic [63:0] e, input logic [63:0] e2);
		@(posedge clk);
		req <= {1'b1, 1'b0, 1'b0, 1'b0, a, 64'h0};
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
		check({rsp.rvalid, rsp.rdata}, {1'b1, e});
		check({rsp2.rvalid, rsp2.rdata}, {1'b1, e2});
	endtask : rd

	task automatic hw_event(input logic [63:0] v);
		@(posedge clk);
		ev <= {1'b1, v};
		@(posedge clk);
		ev.valid <= 1'b0;
	endtask : hw_event

	task automatic fire_wait(input int n);
		@(posedge clk);
		crit <= 1'b1;
		@(posedge clk);
		crit <= 1'b0;
		for (int i = 0; i < 30 && cnt < n; i++) @(posedge clk);
		check(97'(cnt), 97'(n));
	endtask : fire_wait

	task automatic close_out;
		$display("Checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		close_out;
	end

	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rd(ID0_OFF, 64'h0D, 64'h0D);
		rd(ID1_OFF, 64'hF0, 64'hF0);
		rd(ID2_OFF, 64'h05, 64'h05);
		rd(ID3_OFF, 64'hB1, 64'h0);
		wr(ID3_OFF, 64'hFF, 1'b0, 1'b0);
		rd(ID3_OFF, 64'hB1, 64'h0);
		rd(12'h100, 64'h0, 64'h0);
		// Status filter, both revisions side by side
		hw_event(64'h7800_1234);
		rd(STATUS_OFF, 64'h7800_1234, 64'h7800_1234);
		wr(STATUS_OFF, 64'h0000_00AB_4000_0055, 1'b0, 1'b0);
		rd(STATUS_OFF, 64'h7800_1234, 64'h0000_00AB_7800_1234);
		wr(STATUS_OFF, 64'h2000_0000, 1'b0, 1'b0);
		rd(STATUS_OFF, 64'h7800_1234, 64'h7800_1234);
		wr(STATUS_OFF, 64'h6800_0000, 1'b0, 1'b0);
		rd(STATUS_OFF, 64'h1000_0000, 64'h1000_0000);
		hw_event(64'h4100_0000);
		wr(STATUS_OFF, 64'h4000_0000, 1'b0, 1'b0);
		rd(STATUS_OFF, 64'h5100_0000, 64'h5100_0000);
		// Critical interrupt configuration
		wr(CRIT_ATTR_OFF, 64'h80, 1'b0, 1'b0);
		wr(CRIT_ADDR_OFF, 64'hFFFF_1234_5678_9ABF, 1'b0, 1'b0);
		wr(CRIT_PAYLOAD_OFF, 64'h1111_2222_A5A5_5A5A, 1'b0, 1'b0);
		rd(IRQCFG5_OFF, 64'h0000_0080_A5A5_5A5A, 64'h0);
		rd(CRIT_ADDR_OFF, 64'h0000_1234_5678_9ABC, 64'h0);
		rd(IRQCFG4_OFF, 64'h0000_1234_5678_9ABC, 64'h0);
		wr(CRIT_PAYLOAD_OFF, 64'h77, 1'b1, 1'b0);
		wr(IRQCFG5_OFF, 64'h66, 1'b0, 1'b1);
		wr(CRIT_ADDR_OFF, 64'h40, 1'b1, 1'b0);
		rd(CRIT_PAYLOAD_OFF, 64'hA5A5_5A5A, 64'h0);
		rd(CRIT_ADDR_OFF, 64'h0000_1234_5678_9ABC, 64'h0);
		fire_wait(1);
		check(last, {64'h0000_1234_5678_9ABC, 32'hA5A5_5A5A, 1'b0});
		check(97'(msi2_valid), 97'h0);
		// Nonsecure target opens the registers to lower privilege
		wr(CRIT_ATTR_OFF, 64'hC0, 1'b0, 1'b0);
		stall <= 4'h5;
		wr(CRIT_PAYLOAD_OFF, 64'h0BAD_F00D, 1'b1, 1'b0);
		rd(CRIT_ATTR_OFF, 64'hC0, 64'h0);
		fire_wait(2);
		check(last, {64'h0000_1234_5678_9ABC, 32'h0BAD_F00D, 1'b1});
		close_out;
	end
endmodule : error_record_regs_test
